/* File: dv/port_a_low_pin_mux_properties.sv */
// checker for the port A low pin multiplexer: routing and latency
// assumes it is bound to port_a_low_pin_mux and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module port_a_low_pin_mux_checker
    import port_a_low_pin_mux_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pads and analog switches
    input wire logic [3:0] pad_in,
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe_n,
    input wire logic usb_minus_line_connect,
    input wire logic usb_plus_line_connect,
    // configuration
    input wire logic [15:0] port_a_low_config,
    input wire logic [7:0] timer_b_remap_option,
    input wire logic [3:0] timer_b_channel_output_enable,
    input wire logic [1:0] serial_b_mode_select,
    input wire logic [7:0] serial_b_spi_config,
    // peripheral sides
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] timer_b_channel_out,
    input wire logic [3:0] timer_b_channel_in_sel,
    input wire logic serial_b_mosi_out,
    input wire logic serial_b_twowire_data_out,
    input wire logic serial_b_miso_in,
    input wire logic serial_b_slave_select_n
);
    logic [2:0] up_r;
    logic ready;

    // -------------------------------------------------------------
    // warm-up counter
    // -------------------------------------------------------------
    // wait out the reset synchroniser and the pad pipeline before judging
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h7) begin
            up_r <= up_r + 3'h1;
        end
    end
    assign ready = (up_r == 3'h7);

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    usb_minus_link_a: assert property (ready |-> usb_minus_line_connect == ($past(port_a_low_config[3:0]) == 4'h0))
        else $error("usb minus switch wrong");
    usb_plus_link_a: assert property (ready |-> usb_plus_line_connect == ($past(port_a_low_config[7:4]) == 4'h0))
        else $error("usb plus switch wrong");
    timer_in_sel_a: assert property (ready |-> timer_b_channel_in_sel == ~$past(timer_b_remap_option[7:4]))
        else $error("timer input select wrong");
    timer_pin0_drive_a: assert property (ready && $past(port_a_low_config[3:0] == 4'h9 &&
        !timer_b_remap_option[4] && timer_b_channel_output_enable[0])
        |-> !pad_oe_n[0] && pad_out[0] == $past(timer_b_channel_out[0]))
        else $error("pin 0 timer drive wrong");
    spi_master_out_a: assert property (ready && $past(port_a_low_config[3:0] == 4'h9 &&
        serial_b_mode_select == SER_SPI && serial_b_spi_config[4] &&
        (!timer_b_channel_output_enable[0] || timer_b_remap_option[4]))
        |-> !pad_oe_n[0] && pad_out[0] == $past(serial_b_mosi_out))
        else $error("pin 0 spi drive wrong");
    twowire_data_od_a: assert property (ready && $past(port_a_low_config[7:4] == 4'hD &&
        serial_b_mode_select == SER_TWI &&
        (!timer_b_channel_output_enable[2] || timer_b_remap_option[6]))
        |-> pad_out[1] == 1'b0 && pad_oe_n[1] == $past(serial_b_twowire_data_out))
        else $error("pin 1 two-wire drive wrong");
    slave_select_in_a: assert property (ready && $past(port_a_low_config[15:12]) != 4'h0 |->
        serial_b_slave_select_n == (($past(serial_b_mode_select) == SER_SPI && !$past(serial_b_spi_config[4]))
        ? $past(pad_in[3], 3) : 1'b1))
        else $error("slave select wrong");
    master_in_a: assert property (ready && $past(port_a_low_config[7:4]) != 4'h0 |->
        serial_b_miso_in == (($past(serial_b_mode_select) == SER_SPI && $past(serial_b_spi_config[4]))
        ? $past(pad_in[1], 3) : 1'b0))
        else $error("master data in wrong");
    gpio_drive_a: assert property (ready && $past(port_a_low_config[15:12]) == 4'h1 |->
        !pad_oe_n[3] && pad_out[3] == $past(gpio_out[3]))
        else $error("pin 3 gpio drive wrong");
    input_release_a: assert property (ready && $past(port_a_low_config[15:12]) == 4'h4 |-> pad_oe_n[3])
        else $error("pin 3 input drives");
endmodule

bind port_a_low_pin_mux port_a_low_pin_mux_checker chk_i (.*);

`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the port A low pin multiplexer
// assumes package and checker compiled first
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import port_a_low_pin_mux_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] pad_in = 4'h0, gpio_out = 4'h0, timer_b_channel_out = 4'h0, timer_b_channel_output_enable = 4'h0;
    logic [15:0] port_a_low_config = 16'h4444;
    logic [7:0] timer_b_remap_option = 8'h00, serial_b_spi_config = 8'h00;
    logic [1:0] serial_b_mode_select = 2'h0;
    logic serial_b_mosi_out = 1'b0, serial_b_miso_out = 1'b0, serial_b_spi_clock_out = 1'b0;
    logic serial_b_twowire_data_out = 1'b1, serial_b_twowire_clock_out = 1'b1;
    logic [31:0] other_pins_in = 32'h5AC3_96F0;
    logic [4:0] ext_int_c_source_select = 5'h04, ext_int_d_source_select = 5'h04;
    logic [3:0] pad_out, pad_oe_n, gpio_in, timer_b_channel_in, timer_b_channel_in_sel;
    logic usb_minus_line_connect, usb_plus_line_connect, serial_b_mosi_in, serial_b_miso_in;
    logic serial_b_spi_clock_in, serial_b_slave_select_n, serial_b_twowire_data_in, serial_b_twowire_clock_in;
    logic external_interrupt_c, external_interrupt_d;
    int failures = 0;
    int tests_run = 0;

    always #2 sys_clk = ~sys_clk;

    port_a_low_pin_mux dut (.*);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // pad path is three edges; four covers all
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic end_of_test();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_usb_gpio();
        port_a_low_config = 16'h4400;
        pad_in = 4'hF;
        settle();
        chk({usb_minus_line_connect, usb_plus_line_connect}, 2'h3);
        chk(gpio_in, 4'hC);
        port_a_low_config = 16'h1111;
        gpio_out = 4'hA;
        settle();
        chk({pad_oe_n, pad_out}, 8'h0A);
        port_a_low_config = 16'h5555;
        settle();
        chk({pad_oe_n, pad_out}, 8'hA0);
        port_a_low_config = 16'h4444;
        pad_in = 4'h5;
        settle();
        chk({pad_oe_n, gpio_in, usb_minus_line_connect}, 9'h1EA);
    endtask

    // timer owns all pins, outranking spi master
    task automatic t_timer_spi_master();
        port_a_low_config = 16'h9999;
        timer_b_channel_output_enable = 4'hF;
        timer_b_channel_out = 4'h6;
        serial_b_mode_select = SER_SPI;
        serial_b_spi_config = 8'h10;
        serial_b_mosi_out = 1'b1;
        serial_b_spi_clock_out = 1'b1;
        pad_in = 4'hB;
        settle();
        chk({pad_oe_n, pad_out}, 8'h0A);
        chk({timer_b_channel_in_sel, timer_b_channel_in}, 8'hF7);
        timer_b_remap_option = 8'hF0;
        settle();
        chk({pad_oe_n[2], pad_oe_n[0], pad_out[2], pad_out[0]}, 4'h3);
        chk({timer_b_channel_in_sel, timer_b_channel_in}, 8'h00);
        chk({serial_b_miso_in, serial_b_mosi_in, serial_b_spi_clock_in, serial_b_slave_select_n}, 4'h9);
    endtask

    task automatic t_spi_slave();
        serial_b_spi_config = 8'h00;
        serial_b_miso_out = 1'b1;
        pad_in = 4'h5;
        settle();
        chk({pad_oe_n[1], pad_out[1]}, 2'h1);
        chk({serial_b_miso_in, serial_b_mosi_in, serial_b_spi_clock_in, serial_b_slave_select_n}, 4'h6);
    endtask

    task automatic t_twowire();
        serial_b_mode_select = SER_TWI;
        timer_b_remap_option = 8'h00;
        timer_b_channel_output_enable = 4'h0;
        port_a_low_config = 16'h4DD4;
        serial_b_twowire_data_out = 1'b0;
        pad_in = 4'h4;
        settle();
        chk({pad_oe_n[2:1], pad_out[2:1]}, 4'h8);
        chk({serial_b_twowire_data_in, serial_b_twowire_clock_in}, 2'h1);
        // plain alt code refuses open drain
        port_a_low_config = 16'h4994;
        settle();
        chk(pad_oe_n[2:1], 2'h3);
    endtask

    task automatic t_ext_int();
        for (int i = 4; i < 32; i++) begin
            ext_int_c_source_select = 5'(i);
            ext_int_d_source_select = 5'(35 - i);
            settle();
            chk({external_interrupt_c, external_interrupt_d}, {other_pins_in[i], other_pins_in[35 - i]});
        end
        port_a_low_config = 16'h4444;
        ext_int_c_source_select = 5'h02;
        settle();
        chk(external_interrupt_c, pad_in[2]);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        chk({pad_oe_n, serial_b_slave_select_n}, 5'h1F);
        rst_n = 1'b1;
        settle();
        t_usb_gpio();
        t_timer_spi_master();
        t_spi_slave();
        t_twowire();
        t_ext_int();
        end_of_test();
    end

    // run is under two hundred cycles
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire

/* File: hw/port_a_low_pin_mux.sv */
// pin multiplexer for port A pins 0 to 3: routes each pad among
// digital I/O, timer B channels and serial controller B, and pins 0 and 1 to the USB lines
// assumes control inputs are sys_clk registers and
// that pad inputs are asynchronous; the top level resolves pad wires
`timescale 1ns/10ps
`default_nettype none
`include "port_a_low_pin_mux_consts.svh"

module port_a_low_pin_mux
    import port_a_low_pin_mux_pkg::*;
#(
    parameter int NUM_GPIO = 32,
    parameter int SEL_W = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // package pads
    input wire logic [3:0] pad_in,
    output logic [3:0] pad_out,
    output logic [3:0] pad_oe_n,
    // analog switches to the USB transceiver
    output logic usb_minus_line_connect,
    output logic usb_plus_line_connect,
    // configuration
    input wire logic [15:0] port_a_low_config,
    input wire logic [7:0] timer_b_remap_option,
    input wire logic [3:0] timer_b_channel_output_enable,
    input wire logic [1:0] serial_b_mode_select,
    input wire logic [7:0] serial_b_spi_config,
    // general-purpose data
    input wire logic [3:0] gpio_out,
    output logic [3:0] gpio_in,
    // timer B channels, bit 0 is channel 1
    input wire logic [3:0] timer_b_channel_out,
    output logic [3:0] timer_b_channel_in,
    output logic [3:0] timer_b_channel_in_sel,
    // serial controller B, outputs from the controller
    input wire logic serial_b_mosi_out,
    input wire logic serial_b_miso_out,
    input wire logic serial_b_spi_clock_out,
    input wire logic serial_b_twowire_data_out,
    input wire logic serial_b_twowire_clock_out,
    // serial controller B, inputs to the controller
    output logic serial_b_mosi_in,
    output logic serial_b_miso_in,
    output logic serial_b_spi_clock_in,
    output logic serial_b_slave_select_n,
    output logic serial_b_twowire_data_in,
    output logic serial_b_twowire_clock_in,
    // external interrupt pin selection
    input wire logic [NUM_GPIO-1:0] other_pins_in,
    input wire logic [SEL_W-1:0] ext_int_c_source_select,
    input wire logic [SEL_W-1:0] ext_int_d_source_select,
    output logic external_interrupt_c,
    output logic external_interrupt_d
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // decode one four-bit field; unknown codes behave as plain input
    function automatic pin_mode_t decode_cfg(
        input logic [15:0] cfg,
        input int idx
    );
        logic [3:0] f;
        f = cfg[idx*`PA_CFG_FIELD_W +: `PA_CFG_FIELD_W];
        case (f)
            `PA_CFG_ANALOG: decode_cfg = PM_ANALOG;
            `PA_CFG_OUT: decode_cfg = PM_OUT;
            `PA_CFG_OUT_OD: decode_cfg = PM_OUT_OD;
            `PA_CFG_ALT: decode_cfg = PM_ALT;
            `PA_CFG_ALT_OD: decode_cfg = PM_ALT_OD;
            default: decode_cfg = PM_IN;
        endcase
    endfunction

    // pick one pin level out of the whole-device pin vector
    function automatic logic pick_pin(
        input logic [NUM_GPIO-1:0] pins,
        input logic [SEL_W-1:0] sel
    );
        pick_pin = 1'b0;
        for (int k = 0; k < NUM_GPIO; k++) begin
            if (sel == SEL_W'(k)) begin
                pick_pin = pins[k];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    // release is synchronised so every flop leaves reset on one edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // pad input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pad_meta_r;
    logic [3:0] pad_sync_r;
    pin_mode_t mode [4];

    generate
        for (genvar i = 0; i < 4; i++) begin : g_sync
            // the first stage feeds only the second stage
            always_ff @(posedge sys_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    pad_meta_r[i] <= 1'b0;
                    pad_sync_r[i] <= 1'b0;
                end else begin
                    pad_meta_r[i] <= pad_in[i];
                    pad_sync_r[i] <= pad_meta_r[i];
                end
            end
            assign mode[i] = decode_cfg(port_a_low_config, i);
        end
    endgenerate

    // ----------------------------------------------------------------
    // ownership decode
    // ----------------------------------------------------------------
    serial_mode_t ser_mode;
    logic spi_master;
    logic spi_slave;
    logic twi_on;
    logic [3:0] tim_mapped;
    logic [3:0] tim_drives;

    assign ser_mode = serial_mode_t'(serial_b_mode_select);
    // role bit only matters once SPI is chosen
    assign spi_master = (ser_mode == SER_SPI) &&
        serial_b_spi_config[`SB_SPI_MASTER_BIT];  // see RL16
    assign spi_slave = (ser_mode == SER_SPI) &&
        !serial_b_spi_config[`SB_SPI_MASTER_BIT];  // see RL16
    assign twi_on = (ser_mode == SER_TWI);  // see RL16

    // channel lives on this port only while its remap bit is clear
    assign tim_mapped[0] = !timer_b_remap_option[`TB_REMAP_CH1_BIT];  // see RL3
    assign tim_mapped[1] = !timer_b_remap_option[`TB_REMAP_CH3_BIT];  // see RL6
    assign tim_mapped[2] = !timer_b_remap_option[`TB_REMAP_CH4_BIT];  // see RL10
    assign tim_mapped[3] = !timer_b_remap_option[`TB_REMAP_CH2_BIT];  // see RL15

    // the timer output wins the pad over any serial function
    assign tim_drives[0] = tim_mapped[0] &&
        timer_b_channel_output_enable[`TB_CH1_IDX];  // see RL3
    assign tim_drives[1] = tim_mapped[1] &&
        timer_b_channel_output_enable[`TB_CH3_IDX];  // see RL6
    assign tim_drives[2] = tim_mapped[2] &&
        timer_b_channel_output_enable[`TB_CH4_IDX];  // see RL10
    assign tim_drives[3] = tim_mapped[3] &&
        timer_b_channel_output_enable[`TB_CH2_IDX];  // see RL15

    // ----------------------------------------------------------------
    // alternate function source per pin
    // ----------------------------------------------------------------
    logic [3:0] alt_val;
    logic [3:0] alt_en;
    logic [3:0] alt_od;

    // alt_od marks serial open-drain functions, needing the
    // open-drain alternate code; push-pull ones the plain code
    always_comb begin
        alt_val = 4'h0;
        alt_en = 4'h0;
        alt_od = 4'h0;
        // pin 0: timer channel 1, else SPI master data out
        if (tim_drives[0]) begin
            alt_val[0] = timer_b_channel_out[`TB_CH1_IDX];  // see RL3
            alt_en[0] = 1'b1;
        end else if (spi_master) begin
            alt_val[0] = serial_b_mosi_out;  // see RL4
            alt_en[0] = 1'b1;
        end
        // pin 1: timer channel 3, else two-wire data, else slave out
        if (tim_drives[1]) begin
            alt_val[1] = timer_b_channel_out[`TB_CH3_IDX];  // see RL6
            alt_en[1] = 1'b1;
        end else if (twi_on) begin
            alt_val[1] = serial_b_twowire_data_out;  // see RL7
            alt_en[1] = 1'b1;
            alt_od[1] = 1'b1;
        end else if (spi_slave) begin
            alt_val[1] = serial_b_miso_out;  // see RL8
            alt_en[1] = 1'b1;
        end
        // pin 2: timer channel 4, else two-wire clock, else SPI clock
        if (tim_drives[2]) begin
            alt_val[2] = timer_b_channel_out[`TB_CH4_IDX];  // see RL10
            alt_en[2] = 1'b1;
        end else if (twi_on) begin
            alt_val[2] = serial_b_twowire_clock_out;  // see RL11
            alt_en[2] = 1'b1;
            alt_od[2] = 1'b1;
        end else if (spi_master) begin
            alt_val[2] = serial_b_spi_clock_out;  // see RL12
            alt_en[2] = 1'b1;
        end
        // pin 3: only timer channel 2 has an output here
        if (tim_drives[3]) begin
            alt_val[3] = timer_b_channel_out[`TB_CH2_IDX];  // see RL15
            alt_en[3] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    logic [3:0] pad_out_r;
    logic [3:0] pad_oe_n_r;
    logic [3:0] pad_out_nxt;
    logic [3:0] pad_oe_n_nxt;

    // open-drain serial function on the plain alternate code stays off the pad
    // rather than fight a bus it was not set up for
    always_comb begin
        pad_out_nxt = 4'h0;
        pad_oe_n_nxt = 4'hF;
        for (int i = 0; i < 4; i++) begin
            case (mode[i])
                PM_OUT: begin
                    pad_out_nxt[i] = gpio_out[i];  // see RL18
                    pad_oe_n_nxt[i] = 1'b0;
                end
                PM_OUT_OD: begin
                    pad_out_nxt[i] = 1'b0;
                    pad_oe_n_nxt[i] = gpio_out[i];  // see RL18
                end
                PM_ALT: begin
                    if (alt_en[i] && !alt_od[i]) begin
                        pad_out_nxt[i] = alt_val[i];
                        pad_oe_n_nxt[i] = 1'b0;
                    end
                end
                PM_ALT_OD: begin
                    // open drain: only a low is driven
                    if (alt_en[i]) begin
                        pad_out_nxt[i] = 1'b0;
                        pad_oe_n_nxt[i] = alt_val[i];  // see RL7 RL11
                    end
                end
                default: begin
                    // analog and input codes leave the pad released
                    pad_out_nxt[i] = 1'b0;
                    pad_oe_n_nxt[i] = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pad_out_r <= `PA_PAD_OUT_RST;
            pad_oe_n_r <= `PA_PAD_OE_N_RST;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_n_r <= pad_oe_n_nxt;
        end
    end

    assign pad_out = pad_out_r;
    assign pad_oe_n = pad_oe_n_r;

    // ----------------------------------------------------------------
    // USB analog switches
    // ----------------------------------------------------------------
    logic usb_minus_r;
    logic usb_plus_r;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            usb_minus_r <= 1'b0;
            usb_plus_r <= 1'b0;
        end else begin
            usb_minus_r <= (mode[0] == PM_ANALOG);  // see RL1
            usb_plus_r <= (mode[1] == PM_ANALOG);  // see RL2
        end
    end

    assign usb_minus_line_connect = usb_minus_r;
    assign usb_plus_line_connect = usb_plus_r;

    // ----------------------------------------------------------------
    // digital input readback
    // ----------------------------------------------------------------
    logic [3:0] gpio_in_r;
    logic [3:0] pin_level;

    // the input buffer is off in analog mode, so it reads low
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_level[i] = (mode[i] == PM_ANALOG) ? 1'b0 : pad_sync_r[i];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            gpio_in_r <= 4'h0;
        end else begin
            gpio_in_r <= pin_level;  // see RL18
        end
    end

    assign gpio_in = gpio_in_r;

    // ----------------------------------------------------------------
    // timer capture inputs
    // ----------------------------------------------------------------
    logic [3:0] tim_in_r;
    logic [3:0] tim_sel_r;
    logic [3:0] tim_in_nxt;
    logic [3:0] tim_sel_nxt;

    // channels indexed by number, not by pin
    always_comb begin
        tim_sel_nxt[`TB_CH1_IDX] = tim_mapped[0];  // see RL3
        tim_sel_nxt[`TB_CH3_IDX] = tim_mapped[1];  // see RL6
        tim_sel_nxt[`TB_CH4_IDX] = tim_mapped[2];  // see RL10
        tim_sel_nxt[`TB_CH2_IDX] = tim_mapped[3];  // see RL15
        tim_in_nxt[`TB_CH1_IDX] = tim_mapped[0] & pin_level[0];
        tim_in_nxt[`TB_CH3_IDX] = tim_mapped[1] & pin_level[1];
        tim_in_nxt[`TB_CH4_IDX] = tim_mapped[2] & pin_level[2];
        tim_in_nxt[`TB_CH2_IDX] = tim_mapped[3] & pin_level[3];
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tim_in_r <= 4'h0;
            tim_sel_r <= 4'h0;
        end else begin
            tim_in_r <= tim_in_nxt;
            tim_sel_r <= tim_sel_nxt;
        end
    end

    assign timer_b_channel_in = tim_in_r;
    assign timer_b_channel_in_sel = tim_sel_r;

    // ----------------------------------------------------------------
    // serial controller inputs
    // ----------------------------------------------------------------
    logic mosi_in_r;
    logic miso_in_r;
    logic sclk_in_r;
    logic ssel_n_r;
    logic sda_in_r;
    logic scl_in_r;

    // unused inputs idle inactive: select high,
    // two-wire lines high, so no false start
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mosi_in_r <= 1'b0;
            miso_in_r <= 1'b0;
            sclk_in_r <= 1'b0;
            ssel_n_r <= `SB_IDLE_HIGH_RST;
            sda_in_r <= `SB_IDLE_HIGH_RST;
            scl_in_r <= `SB_IDLE_HIGH_RST;
        end else begin
            mosi_in_r <= spi_slave & pin_level[0];  // see RL5
            miso_in_r <= spi_master & pin_level[1];  // see RL9
            sclk_in_r <= spi_slave & pin_level[2];  // see RL13
            ssel_n_r <= !spi_slave | pin_level[3];  // see RL14
            sda_in_r <= !twi_on | pin_level[1];  // see RL7
            scl_in_r <= !twi_on | pin_level[2];  // see RL11
        end
    end

    assign serial_b_mosi_in = mosi_in_r;
    assign serial_b_miso_in = miso_in_r;
    assign serial_b_spi_clock_in = sclk_in_r;
    assign serial_b_slave_select_n = ssel_n_r;
    assign serial_b_twowire_data_in = sda_in_r;
    assign serial_b_twowire_clock_in = scl_in_r;

    // ----------------------------------------------------------------
    // external interrupt source selection
    // ----------------------------------------------------------------
    logic [NUM_GPIO-1:0] all_pins;
    logic irq_c_r;
    logic irq_d_r;

    // own four pins replace their slots in the device vector
    always_comb begin
        all_pins = other_pins_in;
        all_pins[3:0] = pin_level;
    end

    // out-of-range selects read low
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_c_r <= 1'b0;
            irq_d_r <= 1'b0;
        end else begin
            irq_c_r <= pick_pin(all_pins, ext_int_c_source_select);  // see RL17
            irq_d_r <= pick_pin(all_pins, ext_int_d_source_select);  // see RL17
        end
    end

    assign external_interrupt_c = irq_c_r;
    assign external_interrupt_d = irq_d_r;

endmodule

`default_nettype wire

/* File: hw/port_a_low_pin_mux_consts.svh */
// constants for the port A low pin multiplexer: field positions,
// configuration codes, remap bit positions, reset values
// assumes the including file already switched implicit nets off
//
// Notes on behaviour
// RL1 - pin 0 connects to the USB minus line when its field selects analog
// RL2 - pin 1 connects to the USB plus line when its field selects analog
// RL3 - timer B channel 1 uses pin 0 while remap bit 4 is clear
// RL4 - SPI master data out drives pin 0 unless timer channel 1 owns it
// RL5 - SPI slave data in is taken from pin 0
// RL6 - timer B channel 3 uses pin 1 while remap bit 6 is clear
// RL7 - two-wire data uses pin 1 open-drain unless timer channel 3 owns it
// RL8 - SPI slave data out drives pin 1 unless timer channel 3 owns it
// RL9 - SPI master data in is taken from pin 1
// RL10 - timer B channel 4 uses pin 2 while remap bit 7 is clear
// RL11 - two-wire clock uses pin 2 open-drain unless timer channel 4 owns it
// RL12 - SPI master clock drives pin 2 unless timer channel 4 owns it
// RL13 - SPI slave clock is taken from pin 2
// RL14 - SPI slave select, active low, is taken from pin 3
// RL15 - timer B channel 2 uses pin 3 while remap bit 5 is clear
// RL16 - mode picks SPI or two-wire; SPI config bit 4 picks master or slave
// RL17 - external interrupts C and D each select any digital pin
// RL18 - a pin is plain digital I/O unless alternate or analog selected
`ifndef PORT_A_LOW_PIN_MUX_CONSTS_SVH
`define PORT_A_LOW_PIN_MUX_CONSTS_SVH

// ----------------------------------------------------------------
// pin configuration field codes, four bits per pin
// ----------------------------------------------------------------
`define PA_CFG_FIELD_W 4
`define PA_CFG_ANALOG 4'h0
`define PA_CFG_OUT 4'h1
`define PA_CFG_OUT_OD 4'h5
`define PA_CFG_IN 4'h4
`define PA_CFG_IN_PULL 4'h8
`define PA_CFG_ALT 4'h9
`define PA_CFG_ALT_OD 4'hD

// ----------------------------------------------------------------
// timer remap option bits, channel enable bits and the SPI master bit
// ----------------------------------------------------------------
`define TB_REMAP_CH1_BIT 4
`define TB_REMAP_CH2_BIT 5
`define TB_REMAP_CH3_BIT 6
`define TB_REMAP_CH4_BIT 7
`define TB_CH1_IDX 0
`define TB_CH2_IDX 1
`define TB_CH3_IDX 2
`define TB_CH4_IDX 3
`define SB_SPI_MASTER_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PA_PAD_OUT_RST 4'h0
`define PA_PAD_OE_N_RST 4'hF
`define SB_IDLE_HIGH_RST 1'h1

`endif

/* File: hw/port_a_low_pin_mux_pkg.sv */
// types for the port A low pin multiplexer
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package port_a_low_pin_mux_pkg;

    // serial controller B operating mode
    typedef enum logic [1:0] {
        SER_OFF,
        SER_UART,
        SER_SPI,
        SER_TWI
    } serial_mode_t;

    // decoded pin configuration
    typedef enum logic [2:0] {
        PM_ANALOG,
        PM_OUT,
        PM_OUT_OD,
        PM_IN,
        PM_ALT,
        PM_ALT_OD
    } pin_mode_t;

endpackage

`default_nettype wire
